// ===== core/xaso_core.sv
// execution datapath for extended arithmetic and stack operations
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// ****************************************
module xaso_core
  import xaso_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // command
  input wire logic i_start,
  input wire xaso_op_t i_op,
  input wire xaso_size_t i_size,
  input wire logic [19:0] i_dst_val,
  input wire logic [19:0] i_src_val,
  input wire logic [3:0] i_reg_num,
  input wire logic [3:0] i_count_m1,
  input wire logic [19:0] i_sp,
  input wire logic [15:0] i_sr,
  // results
  output logic o_busy,
  output logic o_done,
  output logic o_dst_we,
  output logic [19:0] o_dst_data,
  output logic o_sr_we,
  output logic [15:0] o_sr_data,
  output logic o_sp_we,
  output logic [19:0] o_sp_data,
  // register file
  output logic [3:0] o_rf_raddr,
  input wire logic [19:0] i_rf_rdata,
  output logic o_rf_we,
  output logic [3:0] o_rf_waddr,
  output logic [19:0] o_rf_wdata,
  // memory
  output xaso_mem_t o_mem,
  input wire logic [15:0] i_mem_rdata,
  input wire logic i_mem_ack
);

  xaso_state_t st_r;
  xaso_op_t op_r;
  xaso_size_t size_r;
  logic [3:0] cnt_r;
  logic [3:0] reg_r;
  logic hi_r;
  logic [19:0] sp_r;
  logic [19:0] data_r;
  logic [19:0] sp0_r;
  logic [3:0] cnt0_r;
  logic accept;
  logic alu_op;
  logic acked;
  logic is_save;
  logic need_hi;
  logic item_done;
  logic last_item;
  logic [19:0] sp_step;
  logic [19:0] pop_val;
  logic [19:0] mask;
  logic [19:0] old;
  logic [19:0] res;
  logic [15:0] sr_nxt;
  logic fn;
  logic fz;
  logic fc;
  logic fv;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // ****************************************
  // arithmetic and flag evaluation
  // ****************************************
  assign accept = i_start && (st_r == ST_IDLE);
  assign alu_op = (i_op != OP_SAVE_M) && (i_op != OP_RESTORE_M)
                  && (i_op != OP_RESTORE_1);
  always_comb begin
    mask = xaso_mask(i_size);
    old = i_dst_val & mask;
    unique case (i_op)
      OP_DEC: res = (old - 20'h1) & mask;
      OP_DECD: res = (old - 20'h2) & mask;
      OP_INC: res = (old + 20'h1) & mask;
      OP_INCD: res = (old + 20'h2) & mask;
      OP_INV: res = (old ^ mask) & mask;
      OP_MOVE: res = i_src_val & mask;
      default: res = old;
    endcase
    fn = xaso_msb(i_size, res);
    fz = (res == 20'h0);
    fc = 1'b0;
    fv = 1'b0;
    unique case (i_op)
      OP_DEC: begin
        fc = (old != 20'h0);
        fv = xaso_msb(i_size, old) && !fn;
      end
      OP_DECD: begin
        fc = (old > 20'h1);
        fv = xaso_msb(i_size, old) && !fn;
      end
      OP_INC: begin
        fc = (old == mask);
        fv = (old == (mask >> 1));
      end
      OP_INCD: begin
        fc = (old >= mask - 20'h1);
        fv = (old == (mask >> 1)) || (old == (mask >> 1) - 20'h1);
      end
      OP_INV: begin
        fc = !fz;
        fv = xaso_msb(i_size, old);
      end
      default: ;
    endcase
    // only the four flags move; mode bits pass through untouched
    sr_nxt = i_sr;
    sr_nxt[SR_N] = fn;
    sr_nxt[SR_Z] = fz;
    sr_nxt[SR_C] = fc;
    sr_nxt[SR_V] = fv;
  end

  // ****************************************
  // stack walk helpers
  // ****************************************
  assign acked = (st_r == ST_WAIT) && i_mem_ack;
  assign is_save = (op_r == OP_SAVE_M);
  assign need_hi = (size_r == SZ_AWORD) && !hi_r;
  assign sp_step = is_save ? sp_r - SP_STEP : sp_r + SP_STEP;
  assign item_done = acked && !is_save && !need_hi;
  assign last_item = (cnt_r == 4'h0);
  // the high half arrives second and carries only bits 19:16
  always_comb begin
    if (hi_r) begin
      pop_val = {i_mem_rdata[3:0], data_r[15:0]};
    end else if (size_r == SZ_BYTE) begin
      pop_val = {12'h000, i_mem_rdata[7:0]};
    end else begin
      pop_val = {4'h0, i_mem_rdata};
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= ST_IDLE;
      op_r <= OP_MOVE;
      size_r <= SZ_WORD;
      cnt_r <= 4'h0;
      reg_r <= 4'h0;
      hi_r <= 1'b0;
      sp_r <= RST_WORD20;
      data_r <= RST_WORD20;
      sp0_r <= RST_WORD20;
      cnt0_r <= 4'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_sp_we <= 1'b0;
      o_sp_data <= RST_WORD20;
      o_rf_raddr <= 4'h0;
      o_rf_we <= 1'b0;
      o_rf_waddr <= 4'h0;
      o_rf_wdata <= RST_WORD20;
    end else begin
      o_done <= 1'b0;
      o_sp_we <= 1'b0;
      o_rf_we <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (accept) begin
            op_r <= i_op;
            size_r <= i_size;
            sp_r <= i_sp;
            sp0_r <= i_sp;
            cnt0_r <= i_count_m1;
            o_done <= alu_op;
            if (i_op == OP_SAVE_M) begin
              cnt_r <= i_count_m1;
              reg_r <= i_reg_num;
              o_rf_raddr <= i_reg_num;
              hi_r <= (i_size == SZ_AWORD);
              o_busy <= 1'b1;
              st_r <= ST_RDREG;
            end else if (i_op == OP_RESTORE_M) begin
              cnt_r <= i_count_m1;
              reg_r <= i_reg_num - i_count_m1;
              hi_r <= 1'b0;
              o_busy <= 1'b1;
              st_r <= ST_ISSUE;
            end else if (i_op == OP_RESTORE_1) begin
              cnt_r <= 4'h0;
              hi_r <= 1'b0;
              o_busy <= 1'b1;
              st_r <= ST_ISSUE;
            end
          end
        end
        ST_RDREG: begin
          data_r <= i_rf_rdata;
          st_r <= ST_ISSUE;
        end
        ST_ISSUE: begin
          st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (i_mem_ack) begin
            sp_r <= sp_step;
            if (is_save && hi_r) begin
              hi_r <= 1'b0;
              st_r <= ST_ISSUE;
            end else if (!is_save && need_hi) begin
              data_r <= {4'h0, i_mem_rdata};
              hi_r <= 1'b1;
              st_r <= ST_ISSUE;
            end else begin
              if (op_r == OP_RESTORE_M) begin
                // status register is just another target here
                o_rf_we <= 1'b1;
                o_rf_waddr <= reg_r;
                o_rf_wdata <= pop_val;
              end
              if (last_item) begin
                o_sp_we <= 1'b1;
                o_sp_data <= sp_step;
                o_done <= 1'b1;
                o_busy <= 1'b0;
                st_r <= ST_IDLE;
              end else if (is_save) begin
                cnt_r <= cnt_r - 4'h1;
                reg_r <= reg_r - 4'h1;
                o_rf_raddr <= reg_r - 4'h1;
                hi_r <= (size_r == SZ_AWORD);
                st_r <= ST_RDREG;
              end else begin
                cnt_r <= cnt_r - 4'h1;
                reg_r <= reg_r + 4'h1;
                hi_r <= 1'b0;
                st_r <= ST_ISSUE;
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // memory requests
  // ****************************************
  // save pre-decrements, restore reads at the current pointer
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem <= MEM_IDLE;
    end else if (st_r == ST_ISSUE) begin
      o_mem.req <= 1'b1;
      o_mem.we <= is_save;
      o_mem.addr <= is_save ? sp_r - SP_STEP : sp_r;
      o_mem.wdata <= hi_r ? {12'h000, data_r[19:16]} : data_r[15:0];
    end else if (acked) begin
      o_mem.req <= 1'b0;
    end
  end

  // ****************************************
  // destination and status results
  // ****************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dst_we <= 1'b0;
      o_dst_data <= RST_WORD20;
      o_sr_we <= 1'b0;
      o_sr_data <= RST_WORD16;
    end else if (accept && alu_op) begin
      o_dst_we <= 1'b1;
      o_dst_data <= res;
      o_sr_we <= (i_op != OP_MOVE);
      o_sr_data <= sr_nxt;
    end else if (item_done && (op_r == OP_RESTORE_1)) begin
      // addressing of the destination stays outside the core; only data and write enable leave here
      o_dst_we <= 1'b1;
      o_dst_data <= pop_val;
      o_sr_we <= 1'b0;
    end else begin
      o_dst_we <= 1'b0;
      o_sr_we <= 1'b0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_alu_go(xaso_op_t op);
    accept && (i_op == op);
  endsequence
  sequence s_alu_sized(xaso_op_t op, xaso_size_t sz);
    accept && (i_op == op) && (i_size == sz);
  endsequence
  sequence s_save_end;
    o_sp_we && (op_r == OP_SAVE_M);
  endsequence

  chk_dec_result: assert property (s_alu_go(OP_DEC) |=>
    o_dst_we && o_sr_data[SR_Z] == ($past(old) == 20'h1)
    && o_sr_data[SR_C] == ($past(old) != 20'h0))
    else $error("decrement flags wrong");
  chk_decd_carry: assert property (s_alu_go(OP_DECD) |=>
    o_sr_data[SR_C] == ($past(old) > 20'h1)
    && o_sr_data[SR_Z] == ($past(old) == 20'h2))
    else $error("double decrement flags wrong");
  chk_inc_word_ovf: assert property (s_alu_sized(OP_INC, SZ_WORD)
    |=> o_sr_data[SR_V] == ($past(old) == 20'h07fff)
    && o_sr_data[SR_C] == ($past(old) == 20'h0ffff))
    else $error("increment word flags wrong");
  chk_incd_byte: assert property (s_alu_sized(OP_INCD, SZ_BYTE)
    |=> o_sr_data[SR_Z] == ($past(old) == 20'h000fe)
    && o_dst_data == (($past(old) + 20'h2) & MASK_B))
    else $error("double increment byte wrong");
  chk_inv_flags: assert property (s_alu_go(OP_INV) |=>
    o_sr_data[SR_C] == !o_sr_data[SR_Z]
    && o_dst_data == ($past(old) ^ $past(mask)))
    else $error("invert result or flags wrong");
  chk_mode_bits: assert property (accept && alu_op |=>
    o_sr_data[SR_OSCILLATOR_OFF_BIT:SR_GIE] == $past(i_sr[SR_OSCILLATOR_OFF_BIT:SR_GIE]))
    else $error("mode bits altered");
  chk_move_noflag: assert property (s_alu_go(OP_MOVE) |=>
    o_dst_we && !o_sr_we)
    else $error("move touched flags");
  chk_restore_high: assert property (o_rf_we && size_r == SZ_WORD
    |-> o_rf_wdata[19:16] == 4'h0)
    else $error("restored word kept high bits");
  chk_save_sp: assert property (s_save_end |-> o_sp_data ==
    sp0_r - 20'((32'(cnt0_r) + 32'd1)
    * ((size_r == SZ_AWORD) ? 32'd4 : 32'd2)))
    else $error("save stack pointer wrong");
  chk_pop_sp: assert property (o_sp_we && op_r == OP_RESTORE_1
    |-> o_sp_data == sp0_r + ((size_r == SZ_AWORD) ? 20'h4 : 20'h2))
    else $error("single restore stack pointer wrong");

endmodule // xaso_core
`default_nettype wire

// ===== dv/xaso_core_test.sv
// self-checking bench for the extended arithmetic and stack datapath
`timescale 1ns/1ns
`default_nettype none
module xaso_core_test;
  import xaso_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  xaso_op_t op = OP_DEC;
  xaso_size_t sz = SZ_WORD;
  logic [19:0] dst = 20'h00000;
  logic [19:0] src = 20'h00000;
  logic [3:0] rnum = 4'h0;
  logic [3:0] cm1 = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [19:0] sp = 20'h00100;
  logic [15:0] sr = 16'h013f;
  logic busy, done, dwe, srwe, spwe, rfwe, mack;
  logic [19:0] ddata, spdata, rfrd, rfwd;
  logic [15:0] srdata, mrd;
  logic [3:0] rfra, rfwa;
  xaso_mem_t mem;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;

  xaso_core uut (.i_clk(clk), .i_resetn(resetn), .i_start(start), .i_op(op),
    .i_size(sz), .i_dst_val(dst), .i_src_val(src), .i_reg_num(rnum),
    .i_count_m1(cm1), .i_sp(sp), .i_sr(sr), .o_busy(busy), .o_done(done),
    .o_dst_we(dwe), .o_dst_data(ddata), .o_sr_we(srwe), .o_sr_data(srdata),
    .o_sp_we(spwe), .o_sp_data(spdata), .o_rf_raddr(rfra),
    .i_rf_rdata(rfrd), .o_rf_we(rfwe), .o_rf_waddr(rfwa),
    .o_rf_wdata(rfwd), .o_mem(mem), .i_mem_rdata(mrd), .i_mem_ack(mack));
  xaso_partner pm (.i_clk(clk), .i_resetn(resetn), .i_mem(mem), .i_dly(dly),
    .o_mem_rdata(mrd), .o_mem_ack(mack), .i_rf_raddr(rfra),
    .o_rf_rdata(rfrd), .i_rf_we(rfwe), .i_rf_waddr(rfwa),
    .i_rf_wdata(rfwd));

  always #5 clk = ~clk;
  // a hung handshake would otherwise only time out each go after 400 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [19:0] pat(input int i);
    return 20'h3c5a9 ^ (20'(i) * 20'h11111);
  endfunction

  task automatic go(input int o, input int s, input logic [19:0] d,
                    input logic [3:0] r, input logic [3:0] c1);
    int n;
    @(posedge clk);
    op <= xaso_op_t'(o);
    sz <= xaso_size_t'(s);
    dst <= d;
    src <= ~d;
    rnum <= r;
    cm1 <= c1;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic alu(input int o, input int s, input int k);
    logic [19:0] m, h, d, dm, r;
    logic z, c, v;
    m = s == 0 ? MASK_B : s == 1 ? MASK_W : MASK_A;
    h = (m >> 1) + 20'h00001;
    case (k)
      0: dm = 20'h00000;
      1: dm = 20'h00001;
      2: dm = 20'h00002;
      3: dm = h - 20'h00002;
      4: dm = h - 20'h00001;
      5: dm = h;
      6: dm = m - 20'h00001;
      default: dm = m;
    endcase
    // junk above the operand width must not leak into result or flags
    d = dm | (~m & 20'ha5a5a);
    case (o)
      0: begin
        r = (dm - 20'h00001) & m;
        z = dm == 20'h00001;
        c = dm != 20'h00000;
        v = |(dm & h) & ~|(r & h);
      end
      1: begin
        r = (dm - 20'h00002) & m;
        z = dm == 20'h00002;
        c = dm > 20'h00001;
        v = |(dm & h) & ~|(r & h);
      end
      2: begin
        r = (dm + 20'h00001) & m;
        z = dm == m;
        c = z;
        v = dm == h - 20'h00001;
      end
      3: begin
        r = (dm + 20'h00002) & m;
        z = dm == m - 20'h00001;
        c = dm >= m - 20'h00001;
        v = dm >= h - 20'h00002 && dm < h;
      end
      4: begin
        r = ~dm & m;
        z = r == 20'h00000;
        c = ~z;
        v = |(dm & h);
      end
      default: begin
        r = ~d & m;
        z = 1'b0;
        c = 1'b0;
        v = 1'b0;
      end
    endcase
    go(o, s, d, 4'h0, 4'h0);
    chk(dwe, 1'b1);
    chk(ddata, r);
    if (o == 5) begin
      chk(srwe, 1'b0);
    end else begin
      chk(srwe, 1'b1);
      chk(srdata[8], v);
      chk(srdata[2:0], {|(r & h), z, c});
      chk(srdata & 16'hfef8, sr & 16'hfef8);
    end
  endtask

  // o: 6 multi save, 7 multi restore, 8 single restore
  task automatic stk(input int o, input int s, input logic [3:0] r,
                     input logic [3:0] c1);
    logic [19:0] st, e;
    int a, q, lo;
    a = s == 2 ? 2 : 1;
    st = 20'(2 * a);
    for (int i = 0; i < 16; i++) pm.rf[i] = o == 6 ? pat(i) : 20'hfffff;
    for (int i = 0; i < 64; i++) pm.mem[128 + i] = 16'h6e21 + 16'(i * 2323);
    go(o, s, 20'h00000, r, c1);
    chk(spwe, 1'b1);
    e = o == 6 ? sp - st * (20'(c1) + 20'h1) : sp + st * (20'(c1) + 20'h1);
    chk(spdata, e);
    chk(busy, 1'b0);
    // the last restored register lands in the file one edge after done
    if (o == 7) @(negedge clk);
    for (int k = 0; k <= int'(c1); k++) begin
      if (o == 6) begin
        q = int'(r) - k;
        lo = 128 - a * (k + 1);
        chk(pm.mem[lo], pat(q) & 20'h0ffff);
        if (a == 2) chk(pm.mem[lo + 1], pat(q) >> 16);
        chk(pm.rf[q], pat(q));
      end else begin
        q = int'(r) - int'(c1) + k;
        lo = 128 + a * k;
        e = a == 2 ? {pm.mem[lo + 1][3:0], pm.mem[lo]} : {4'h0, pm.mem[lo]};
        if (o == 7) begin
          chk(pm.rf[q], e);
        end else begin
          if (s == 0) e = e & 20'h000ff;
          chk(dwe, 1'b1);
          chk(ddata, e);
          chk(srwe, 1'b0);
        end
      end
    end
  endtask
  // a start during a walk is ignored; reset then drops the walk at once
  task automatic rst_mid();
    @(posedge clk);
    op <= OP_SAVE_M;
    sz <= SZ_AWORD;
    rnum <= 4'h9;
    cm1 <= 4'h3;
    start <= 1'b1;
    @(posedge clk);
    op <= OP_INC;
    repeat (2) @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    chk(busy, 1'b1);
    chk(dwe, 1'b0);
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    chk(busy, 1'b0);
    chk(mem.req, 1'b0);
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk(done, 1'b0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int o = 0; o < 6; o++) begin
      for (int s = 0; s < 3; s++) begin
        for (int k = 0; k < 8; k++) alu(o, s, k);
      end
    end
    stk(6, 1, 4'h5, 4'h0);
    stk(6, 2, 4'hf, 4'hf);
    stk(7, 1, 4'h3, 4'h1);
    stk(7, 2, 4'hf, 4'hf);
    for (int s = 0; s < 3; s++) stk(8, s, 4'h0, 4'h0);
    rst_mid();
    @(posedge clk);
    dly <= 4'h3;
    stk(6, 2, 4'hd, 4'h4);
    stk(7, 1, 4'hd, 4'h4);
    stk(8, 2, 4'h0, 4'h0);
    conclude();
  end
endmodule // xaso_core_test
`default_nettype wire

// ===== dv/xaso_partner.sv
// behavioural register file and stack memory on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module xaso_partner
  import xaso_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // memory side
  input wire xaso_mem_t i_mem,
  input wire logic [3:0] i_dly,
  output logic [15:0] o_mem_rdata,
  output logic o_mem_ack,
  // register file side
  input wire logic [3:0] i_rf_raddr,
  output logic [19:0] o_rf_rdata,
  input wire logic i_rf_we,
  input wire logic [3:0] i_rf_waddr,
  input wire logic [19:0] i_rf_wdata
);
  logic [15:0] mem [256];
  logic [19:0] rf [16];
  logic [15:0] rd_r;
  logic [3:0] cnt_r;
  // read data is scrambled outside the ack cycle so a late sample shows up
  assign o_mem_rdata = o_mem_ack ? rd_r : ~rd_r;
  assign o_rf_rdata = rf[i_rf_raddr];
  // ****************************************
  // memory answers after i_dly extra cycles
  // ****************************************
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_ack <= 1'b0;
      cnt_r <= 4'h0;
      rd_r <= 16'h0000;
    end else begin
      o_mem_ack <= 1'b0;
      if (i_mem.req && !o_mem_ack) begin
        if (cnt_r == i_dly) begin
          cnt_r <= 4'h0;
          o_mem_ack <= 1'b1;
          rd_r <= mem[i_mem.addr[8:1]];
          if (i_mem.we) mem[i_mem.addr[8:1]] <= i_mem.wdata;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
  always @(posedge i_clk) begin
    if (i_rf_we) rf[i_rf_waddr] <= i_rf_wdata;
  end
endmodule // xaso_partner
`default_nettype wire

// ===== include/xaso_pkg.sv
// shared types and constants for the extended arithmetic and stack block
package xaso_pkg;

  // ****************************************
  // operations, sizes and states
  // ****************************************
  typedef enum logic [3:0] {
    OP_DEC, OP_DECD, OP_INC, OP_INCD, OP_INV, OP_MOVE,
    OP_SAVE_M, OP_RESTORE_M, OP_RESTORE_1
  } xaso_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_AWORD} xaso_size_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RDREG, ST_ISSUE, ST_WAIT} xaso_state_t;

  // ****************************************
  // status register layout
  // ****************************************
  localparam int unsigned SR_C = 0;
  localparam int unsigned SR_Z = 1;
  localparam int unsigned SR_N = 2;
  localparam int unsigned SR_GIE = 3;
  localparam int unsigned SR_PROCESSOR_OFF_BIT = 4;
  localparam int unsigned SR_OSCILLATOR_OFF_BIT = 5;
  localparam int unsigned SR_V = 8;
  localparam logic [3:0] SR_REG_IDX = 4'h2;

  // ****************************************
  // operand masks, stack steps, reset values
  // ****************************************
  localparam logic [19:0] MASK_B = 20'h000ff;
  localparam logic [19:0] MASK_W = 20'h0ffff;
  localparam logic [19:0] MASK_A = 20'hfffff;
  localparam logic [19:0] SP_STEP = 20'h00002;
  localparam logic [19:0] RST_WORD20 = 20'h00000;
  localparam logic [15:0] RST_WORD16 = 16'h0000;

  // memory request carried as one bundle
  typedef struct packed {
    logic req;
    logic we;
    logic [19:0] addr;
    logic [15:0] wdata;
  } xaso_mem_t;

  localparam xaso_mem_t MEM_IDLE = '{1'b0, 1'b0, 20'h00000, 16'h0000};

  function automatic logic [19:0] xaso_mask(input xaso_size_t sz);
    unique case (sz)
      SZ_BYTE: xaso_mask = MASK_B;
      SZ_WORD: xaso_mask = MASK_W;
      default: xaso_mask = MASK_A;
    endcase
  endfunction

  function automatic logic xaso_msb(input xaso_size_t sz,
                                    input logic [19:0] v);
    unique case (sz)
      SZ_BYTE: xaso_msb = v[7];
      SZ_WORD: xaso_msb = v[15];
      default: xaso_msb = v[19];
    endcase
  endfunction

endpackage
